// ==== shared/vin_pkg.sv ====
`default_nettype none
package vin_pkg;
   // =====================================================
   // register offsets
   localparam logic [7:0] OFS_EVEN = 8'hD0;
   localparam logic [7:0] OFS_ODD = 8'hD4;
   localparam logic [7:0] OFS_WM0 = 8'hD8;
   localparam logic [7:0] OFS_WM1 = 8'hDC;
   // =====================================================
   // field positions
   localparam int BASE_MSB = 20;
   localparam int MAXV_LSB = 24;
   localparam int PITCH_LSB = 27;
   localparam int QRES_LSB = 30;
   localparam int ORDER_LSB = 24;
   localparam int HPOL_BIT = 26;
   localparam int VPOL_BIT = 27;
   localparam int APOL_BIT = 28;
   localparam int EVONLY_BIT = 29;
   localparam int MODE_LSB = 30;
   localparam int WM_LSB = 3;
   localparam int WM_MSB = 23;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   // =====================================================
   // capture modes
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_NOVBI = 2'h1;
   localparam logic [1:0] MODE_VBI_LO = 2'h2;
   localparam logic [1:0] MODE_VBI_HI = 2'h3;
   // polarity-corrected link pins
   typedef struct packed {
      logic hsync;
      logic vsync;
      logic active;
      logic vblank;
   } video_ctl_t;
   // one memory word write
   typedef struct packed {
      logic valid;
      logic [23:0] addr;
      logic [31:0] data;
   } mem_wr_t;
endpackage
`default_nettype wire

// ==== rtl/video_input_capture.sv ====
// Function
// - byte-serial 4:2:2 or other byte streams are written to memory
// - even and odd fields have own bases, one shared pitch
// - end-of-field event raised, separately enabled, routed host or processor
// - vsync edge with hsync active is odd field, else even
// - bytes clipped to pitch per line and max lines per field
// - lines with vblank asserted advance address by twice pitch
// - with blanking capture on, active bytes of every line are sampled
// - field starts at vsync inactive; line address advances every line
// - field base in bits 20:0 as byte address divided by eight
// - even register bits 26:24 choose max lines per field
// - even register bits 29:27 choose line pitch in bytes
// - even register bits 31:30 reserve queue entries while enabled
// - odd register bits 25:24 permute four bytes into one word
// - odd register bits 26..28 set hsync, vsync, active polarity high
// - odd register bit 29 keeps even fields only
// - odd register bits 31:30 select off, capture, capture with blanking
// - memory writes matching either match address raise their event
`timescale 1ns/1ps
`default_nettype none
module video_input_capture
(
   input wire logic CLK,
   input wire logic RESET_N,
   input wire logic REG_WR,
   input wire logic [7:0] REG_ADDR,
   input wire logic [31:0] REG_WDATA,
   output logic [31:0] REG_RDATA,
   input wire logic SAMPLE_CLK,
   input wire logic [7:0] VIDEO_DATA,
   input wire logic HSYNC,
   input wire logic VSYNC,
   input wire logic ACTIVE,
   input wire logic VBLANK,
   input wire logic LMEM_WR,
   input wire logic [23:0] LMEM_ADDR,
   input wire logic FIELD_INT_EN,
   input wire logic FIELD_INT_TO_RISC,
   input wire logic [1:0] MATCH_INT_EN,
   output logic MEM_WR,
   output logic [23:0] MEM_ADDR,
   output logic [31:0] MEM_DATA,
   output logic [2:0] STORE_QUEUE_RESERVE,
   output logic FIELD_IS_ODD,
   output logic FIELD_DONE_HOST,
   output logic FIELD_DONE_RISC,
   output logic WRITE_MATCH_EVENT_0,
   output logic WRITE_MATCH_EVENT_1
);
   // =====================================================
   // reset release
   logic rst_s1_q, rst_n;
   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N) {rst_n, rst_s1_q} <= 2'b00;
      else {rst_n, rst_s1_q} <= {rst_s1_q, 1'b1};
   end

   // =====================================================
   // registers
   logic [31:0] even_q, odd_q, wm0_q, wm1_q;
   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         even_q <= vin_pkg::CTRL_RESET;
         odd_q <= vin_pkg::CTRL_RESET; // mode off
         wm0_q <= vin_pkg::CTRL_RESET;
         wm1_q <= vin_pkg::CTRL_RESET;
      end
      else if (REG_WR)
      begin
         if (REG_ADDR == vin_pkg::OFS_EVEN) even_q <= REG_WDATA;
         if (REG_ADDR == vin_pkg::OFS_ODD) odd_q <= REG_WDATA;
         if (REG_ADDR == vin_pkg::OFS_WM0) wm0_q <= REG_WDATA;
         if (REG_ADDR == vin_pkg::OFS_WM1) wm1_q <= REG_WDATA;
      end
   end

   // read mux
   wire [31:0] rd_d = (REG_ADDR == vin_pkg::OFS_EVEN) ? even_q :
                      (REG_ADDR == vin_pkg::OFS_ODD) ? odd_q :
                      (REG_ADDR == vin_pkg::OFS_WM0) ? wm0_q :
                      (REG_ADDR == vin_pkg::OFS_WM1) ? wm1_q : 32'h0000_0000;

   // =====================================================
   // field decode
   wire [20:0] even_base = even_q[vin_pkg::BASE_MSB:0];
   wire [20:0] odd_base = odd_q[vin_pkg::BASE_MSB:0];
   wire [2:0] maxv_code = even_q[vin_pkg::MAXV_LSB +: 3];
   wire [2:0] pitch_code = even_q[vin_pkg::PITCH_LSB +: 3];
   wire [1:0] qres_code = even_q[vin_pkg::QRES_LSB +: 2];
   wire [1:0] order = odd_q[vin_pkg::ORDER_LSB +: 2];
   wire hpol = odd_q[vin_pkg::HPOL_BIT];
   wire vpol = odd_q[vin_pkg::VPOL_BIT];
   wire apol = odd_q[vin_pkg::APOL_BIT];
   wire even_only = odd_q[vin_pkg::EVONLY_BIT];
   wire [1:0] mode = odd_q[vin_pkg::MODE_LSB +: 2];
   wire enabled = (mode != vin_pkg::MODE_OFF);
   wire vbi_on = mode[1];

   // max lines table
   logic [9:0] max_lines;
   always_comb
   begin
      case (maxv_code)
         3'h0: max_lines = 10'd240;
         3'h1: max_lines = 10'd263;
         3'h2: max_lines = 10'd287;
         3'h3: max_lines = 10'd313;
         3'h4: max_lines = 10'd540;
         3'h5: max_lines = 10'd590;
         3'h6: max_lines = 10'd720;
         default: max_lines = 10'd788;
      endcase
   end

   // pitch table
   logic [12:0] pitch;
   always_comb
   begin
      case (pitch_code)
         3'h0: pitch = 13'd1280;
         3'h1: pitch = 13'd1536;
         3'h2: pitch = 13'd1600;
         3'h3: pitch = 13'd2048;
         3'h4: pitch = 13'd2560;
         3'h5: pitch = 13'd3072;
         3'h6: pitch = 13'd3200;
         default: pitch = 13'd4096;
      endcase
   end

   // queue reservation, only while enabled
   logic [2:0] qres;
   always_comb
   begin
      case (qres_code)
         2'h0: qres = 3'd1;
         2'h1: qres = 3'd2;
         2'h2: qres = 3'd4;
         default: qres = 3'd6;
      endcase
   end

   // =====================================================
   // link pin synchronisers
   logic [12:0] s1_q, s2_q;
   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s1_q <= 13'h0000;
         s2_q <= 13'h0000;
      end
      else
      begin
         s1_q <= {SAMPLE_CLK, VBLANK, ACTIVE, VSYNC, HSYNC, VIDEO_DATA};
         s2_q <= s1_q;
      end
   end

   // polarity correction
   vin_pkg::video_ctl_t ctl;
   assign ctl = {s2_q[8] ~^ hpol,
                 s2_q[9] ~^ vpol,
                 s2_q[10] ~^ apol,
                 s2_q[11] ~^ mode[0]};
   wire [7:0] pix = s2_q[7:0];

   logic sclk_q;
   vin_pkg::video_ctl_t prev_q;
   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sclk_q <= 1'b0;
         prev_q <= '0;
      end
      else
      begin
         sclk_q <= s2_q[12];
         if (s2_q[12] && !sclk_q) prev_q <= ctl;
      end
   end

   // sample-clock rising edge enable
   wire tick = s2_q[12] && !sclk_q;
   wire vs_rise = tick && ctl.vsync && !prev_q.vsync;
   wire vs_fall = tick && !ctl.vsync && prev_q.vsync;
   wire hs_end = tick && !ctl.hsync && prev_q.hsync;

   // =====================================================
   // capture state
   logic in_field_q, odd_q2, store_q, line_vbi_q;
   logic [9:0] line_q;
   logic [23:0] line_addr_q;
   logic [12:0] byte_q;
   logic [23:0] word_q;
   logic [1:0] lane_q;
   logic [31:0] acc_q;
   vin_pkg::mem_wr_t wr_q;
   logic fdone_q;

   // field write decisions
   wire field_store = enabled && !(even_only && odd_q2);
   wire take = tick && in_field_q && store_q && ctl.active &&
               (!ctl.vblank || vbi_on);
   wire in_clip = (line_q < max_lines) && (byte_q < pitch);
   wire [13:0] step = line_vbi_q ? {pitch, 1'b0} : {1'b0, pitch};
   wire [23:0] base_b = {odd_q2 ? odd_base : even_base, 3'b000};

   // byte order packing
   logic [31:0] acc_d;
   always_comb
   begin
      acc_d = acc_q;
      case ({order, lane_q})
         4'h0: acc_d[31:24] = pix;
         4'h1: acc_d[7:0] = pix;
         4'h2: acc_d[15:8] = pix;
         4'h3: acc_d[23:16] = pix;
         4'h4: acc_d[15:8] = pix;
         4'h5: acc_d[7:0] = pix;
         4'h6: acc_d[31:24] = pix;
         4'h7: acc_d[23:16] = pix;
         4'h8: acc_d[7:0] = pix;
         4'h9: acc_d[15:8] = pix;
         4'hA: acc_d[23:16] = pix;
         4'hB: acc_d[31:24] = pix;
         4'hC: acc_d[7:0] = pix;
         4'hD: acc_d[31:24] = pix;
         4'hE: acc_d[23:16] = pix;
         default: acc_d[15:8] = pix;
      endcase
   end

   // line/byte counters and word writes
   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         in_field_q <= 1'b0;
         odd_q2 <= 1'b0;
         store_q <= 1'b0;
         line_vbi_q <= 1'b0;
         line_q <= 10'd0;
         line_addr_q <= 24'h000000;
         byte_q <= 13'd0;
         word_q <= 24'h000000;
         lane_q <= 2'd0;
         acc_q <= 32'h0000_0000;
         wr_q <= '0;
         fdone_q <= 1'b0;
      end
      else
      begin
         wr_q.valid <= 1'b0;
         fdone_q <= 1'b0;
         if (vs_rise)
         begin
            odd_q2 <= ctl.hsync;
            fdone_q <= in_field_q && store_q;
            in_field_q <= 1'b0;
         end
         else if (vs_fall)
         begin
            in_field_q <= 1'b1;
            store_q <= field_store;
            line_q <= 10'd0;
            line_addr_q <= base_b;
            byte_q <= 13'd0;
            lane_q <= 2'd0;
            line_vbi_q <= ctl.vblank;
         end
         else if (hs_end && in_field_q)
         begin
            line_q <= line_q + 10'd1;
            line_addr_q <= line_addr_q + {10'h000, step};
            byte_q <= 13'd0;
            lane_q <= 2'd0;
            line_vbi_q <= ctl.vblank;
         end
         else if (take)
         begin
            byte_q <= byte_q + 13'd1;
            lane_q <= lane_q + 2'd1;
            acc_q <= acc_d;
            if (lane_q == 2'd0) word_q <= line_addr_q + {11'h000, byte_q};
            if (lane_q == 2'd3 && in_clip)
            begin
               wr_q.valid <= 1'b1;
               wr_q.addr <= word_q;
               wr_q.data <= acc_d;
            end
         end
      end
   end

   // =====================================================
   // outputs and write-match events
   wire m0 = LMEM_WR && MATCH_INT_EN[0] &&
             (LMEM_ADDR[23:3] == wm0_q[vin_pkg::WM_MSB:vin_pkg::WM_LSB]);
   wire m1 = LMEM_WR && MATCH_INT_EN[1] &&
             (LMEM_ADDR[23:3] == wm1_q[vin_pkg::WM_MSB:vin_pkg::WM_LSB]);
   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         REG_RDATA <= 32'h0000_0000;
         MEM_WR <= 1'b0;
         MEM_ADDR <= 24'h000000;
         MEM_DATA <= 32'h0000_0000;
         STORE_QUEUE_RESERVE <= 3'd0;
         FIELD_IS_ODD <= 1'b0;
         FIELD_DONE_HOST <= 1'b0;
         FIELD_DONE_RISC <= 1'b0;
         WRITE_MATCH_EVENT_0 <= 1'b0;
         WRITE_MATCH_EVENT_1 <= 1'b0;
      end
      else
      begin
         REG_RDATA <= rd_d;
         MEM_WR <= wr_q.valid;
         MEM_ADDR <= wr_q.addr;
         MEM_DATA <= wr_q.data;
         STORE_QUEUE_RESERVE <= enabled ? qres : 3'd0;
         FIELD_IS_ODD <= odd_q2;
         FIELD_DONE_HOST <= fdone_q && FIELD_INT_EN && !FIELD_INT_TO_RISC;
         FIELD_DONE_RISC <= fdone_q && FIELD_INT_EN && FIELD_INT_TO_RISC;
         WRITE_MATCH_EVENT_0 <= m0;
         WRITE_MATCH_EVENT_1 <= m1;
      end
   end

   // =====================================================
   // checks
   clip_lines_a: assert property (@(posedge CLK) disable iff (!rst_n)
      wr_q.valid |-> $past(line_q) < max_lines) else $error("line clip");
   match_event_a: assert property (@(posedge CLK) disable iff (!rst_n)
      m0 |=> WRITE_MATCH_EVENT_0) else $error("match 0 lost");
   match_one_a: assert property (@(posedge CLK) disable iff (!rst_n)
      m1 |=> WRITE_MATCH_EVENT_1) else $error("match 1 lost");
   off_reserve_a: assert property (@(posedge CLK) disable iff (!rst_n)
      !enabled |=> STORE_QUEUE_RESERVE == 3'd0) else $error("queue held");
   field_parity_a: assert property (@(posedge CLK) disable iff (!rst_n)
      vs_rise |=> odd_q2 == $past(ctl.hsync)) else $error("parity");
   field_start_a: assert property (@(posedge CLK) disable iff (!rst_n)
      vs_fall |=> in_field_q && line_q == 10'd0) else $error("start");
   done_route_a: assert property (@(posedge CLK) disable iff (!rst_n)
      fdone_q && FIELD_INT_EN |=> FIELD_DONE_HOST || FIELD_DONE_RISC)
      else $error("field done");
   even_only_a: assert property (@(posedge CLK) disable iff (!rst_n)
      vs_fall && even_only && odd_q2 |=> !store_q) else $error("odd kept");
   mem_pipe_a: assert property (@(posedge CLK) disable iff (!rst_n)
      wr_q.valid |=> MEM_WR ##1 !MEM_WR) else $error("write pulse");
endmodule
`default_nettype wire

// ==== testbench/video_source_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// =====================================
// video source on the capture link
module video_source_model
(
   input wire logic clk,
   input wire logic [3:0] pol_high,
   output logic sclk,
   output logic [7:0] vdata,
   output logic hs_pin,
   output logic vs_pin,
   output logic act_pin,
   output logic vb_pin
);
   logic hs = 1'b0;
   logic vs = 1'b0;
   logic act = 1'b0;
   logic vb = 1'b0;
   // pins take the logical levels at each clock edge, in the programmed polarity
   always @(posedge clk)
   begin
      hs_pin <= hs ~^ pol_high[0];
      vs_pin <= vs ~^ pol_high[1];
      act_pin <= act ~^ pol_high[2];
      vb_pin <= vb ~^ pol_high[3];
   end
   // sample clock stands still between transfers
   initial
   begin
      sclk = 1'b0;
      vdata = 8'h00;
   end
   // one eight-clock sample period; idle data shows its inverse
   task automatic tick(input logic [7:0] d);
      vdata <= act ? d : ~vdata;
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      repeat (4) @(posedge clk);
      sclk <= 1'b0;
   endtask
   // vsync leading edge, hsync level gives parity
   task automatic vs_edge(input logic odd);
      @(posedge clk);
      vs = 1'b0;
      tick(8'h00);
      hs = odd;
      vs = 1'b1;
      tick(8'h00);
      tick(8'h00);
      hs = 1'b0;
      tick(8'h00);
   endtask
   // one field; line 0 may be a blanking line
   task automatic field(input logic nxt, input int nl, n0, n, input logic vb0);
      @(posedge clk);
      vb = vb0;
      vs = 1'b0;
      tick(8'h00);
      for (int l = 0; l < nl; l++)
      begin
         act = 1'b1;
         for (int i = 0; i < ((l == 0) ? n0 : n); i++)
            tick(8'(l * 7 + i));
         act = 1'b0;
         hs = 1'b1;
         tick(8'h00);
         hs = 1'b0;
         vb = 1'b0;
         tick(8'h00);
      end
      hs = nxt;
      vs = 1'b1;
      tick(8'h00);
      tick(8'h00);
      hs = 1'b0;
      tick(8'h00);
   endtask
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam int PITCH [8] = '{1280, 1536, 1600, 2048, 2560, 3072, 3200, 4096};
   localparam int MAXL [8] = '{240, 263, 287, 313, 540, 590, 720, 788};
   localparam int QENT [4] = '{1, 2, 4, 6};
   localparam logic [7:0] PERM [4] = '{8'h93, 8'hB1, 8'hE4, 8'h6C};
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic reg_wr = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic lmem_wr = 1'b0;
   logic [23:0] lmem_addr = 24'h0;
   logic int_en = 1'b0;
   logic to_risc = 1'b0;
   logic [1:0] m_en = 2'h0;
   logic [3:0] pol = 4'hF;
   logic [31:0] reg_rdata, mem_data;
   logic sclk, hs, vs, act, vb, mem_wr, fodd, done_h, done_r, ev0, ev1;
   logic [7:0] vdata;
   logic [23:0] mem_addr;
   logic [2:0] sq_res;
   logic [20:0] base_e = 21'h00100;
   logic [20:0] base_o = 21'h02000;
   logic [2:0] pc = 3'h0;
   logic [2:0] mc = 3'h0;
   logic [1:0] qc = 2'h1;
   logic [1:0] order = 2'h2;
   logic [1:0] mode = 2'h3;
   logic evonly = 1'b0;
   logic par = 1'b0;
   int failures = 0;
   int check_count = 0;
   int nh = 0;
   int nr = 0;
   logic [55:0] expq[$];
   logic [55:0] gotq[$];
   always #50 clk = ~clk;
   video_input_capture u_dut (.CLK(clk), .RESET_N(reset_n), .REG_WR(reg_wr),
      .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .SAMPLE_CLK(sclk),
      .VIDEO_DATA(vdata), .HSYNC(hs), .VSYNC(vs), .ACTIVE(act), .VBLANK(vb),
      .LMEM_WR(lmem_wr), .LMEM_ADDR(lmem_addr), .FIELD_INT_EN(int_en),
      .FIELD_INT_TO_RISC(to_risc), .MATCH_INT_EN(m_en), .MEM_WR(mem_wr),
      .MEM_ADDR(mem_addr), .MEM_DATA(mem_data), .STORE_QUEUE_RESERVE(sq_res),
      .FIELD_IS_ODD(fodd), .FIELD_DONE_HOST(done_h), .FIELD_DONE_RISC(done_r),
      .WRITE_MATCH_EVENT_0(ev0), .WRITE_MATCH_EVENT_1(ev1));
   video_source_model u_src (.clk(clk), .pol_high(pol), .sclk(sclk), .vdata(vdata),
      .hs_pin(hs), .vs_pin(vs), .act_pin(act), .vb_pin(vb));
   // =====================================
   // collect word writes and end-of-field pulses
   always @(posedge clk)
   begin
      if (mem_wr === 1'b1)
         gotq.push_back({mem_addr, mem_data});
      if (done_h === 1'b1)
         nh++;
      if (done_r === 1'b1)
         nr++;
   end
   task automatic check(input string what, input logic [55:0] e, g);
      check_count++;
      if (g !== e)
      begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // =====================================
   // register access and local memory writes
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      reg_addr <= a;
      @(posedge clk);
      #1 check("register", 56'(e), 56'(reg_rdata));
   endtask
   task automatic cfg;
      wr(vin_pkg::OFS_EVEN, {qc, pc, mc, 3'h0, base_e});
      wr(vin_pkg::OFS_ODD, {mode, evonly, pol[2:0], order, 3'h0, base_o});
   endtask
   task automatic lm(input logic [23:0] a, input logic [1:0] en, exp);
      int c0;
      int c1;
      c0 = 0;
      c1 = 0;
      @(posedge clk);
      lmem_wr <= 1'b1;
      lmem_addr <= a;
      m_en <= en;
      @(posedge clk);
      lmem_wr <= 1'b0;
      repeat (3)
      begin
         #1 c0 += (ev0 === 1'b1);
         c1 += (ev1 === 1'b1);
         @(posedge clk);
      end
      check("match event 0", 56'(exp[0]), 56'(c0));
      check("match event 1", 56'(exp[1]), 56'(c1));
   endtask
   // one field with expected words built from the settings
   task automatic fld(input logic nxt, input int nl, n0, n, input logic vb0);
      int la;
      int cnt;
      int h0;
      int r0;
      logic [31:0] w;
      logic st;
      logic vbl;
      la = 0;
      h0 = nh;
      r0 = nr;
      st = mode != vin_pkg::MODE_OFF && !(par && evonly);
      check("parity", 56'(par), 56'(fodd));
      for (int l = 0; st && l < nl && l < MAXL[mc]; l++)
      begin
         vbl = l == 0 && vb0;
         cnt = (vbl && mode == vin_pkg::MODE_NOVBI) ? 0 : ((l == 0) ? n0 : n);
         cnt = (cnt > PITCH[pc]) ? PITCH[pc] : cnt;
         for (int k = 0; k + 4 <= cnt; k += 4)
         begin
            for (int i = 0; i < 4; i++)
               w[8 * PERM[order][2 * i +: 2] +: 8] = 8'(l * 7 + k + i);
            expq.push_back({24'((par ? base_o : base_e) * 8 + la + k), w});
         end
         la += vbl ? 2 * PITCH[pc] : PITCH[pc];
      end
      u_src.field(nxt, nl, n0, n, vb0);
      repeat (10) @(posedge clk);
      check("word count", 56'(expq.size()), 56'(gotq.size()));
      while (expq.size() > 0 && gotq.size() > 0)
         check("word", expq.pop_front(), gotq.pop_front());
      expq.delete();
      gotq.delete();
      check("done host", 56'(st && int_en && !to_risc), 56'(nh - h0));
      check("done risc", 56'(st && int_en && to_risc), 56'(nr - r0));
      par = nxt;
   endtask
   // =====================================
   // main sequence
   initial
   begin
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge clk);
      for (int i = 0; i < 5; i++)
         rd(8'hD0 + 8'(4 * i), 32'h0);
      check("reserve", 56'h0, 56'(sq_res));
      for (int m = 0; m < 2; m++)
      begin
         wr(m ? vin_pkg::OFS_WM1 : vin_pkg::OFS_WM0, 32'h0012_3458 + 32'(m * 8));
         lm(24'h12_345F + 24'(m * 8), 2'h3, 2'(1 << m));
         lm(24'h12_3450 + 24'(m * 24), 2'h3, 2'h0);
         lm(24'h12_3458 + 24'(m * 8), 2'h0, 2'h0);
      end
      for (int q = 0; q < 4; q++)
      begin
         qc = 2'(q);
         cfg;
         repeat (2) @(posedge clk);
         #1 check("reserve", 56'(QENT[q]), 56'(sq_res));
      end
      rd(vin_pkg::OFS_EVEN, {qc, pc, mc, 3'h0, base_e});
      qc = 2'h1;
      int_en <= 1'b1;
      cfg;
      u_src.vs_edge(1'b0);
      fld(1'b1, 2, 8, 8, 1'b0);
      to_risc <= 1'b1;
      for (int o = 0; o < 4; o++)
      begin
         order = 2'(o);
         cfg;
         fld(1'b1, 1, 4, 4, 1'b0);
      end
      evonly = 1'b1;
      cfg;
      fld(1'b0, 1, 4, 4, 1'b0);
      mode = vin_pkg::MODE_NOVBI;
      pc = 3'h1;
      cfg;
      fld(1'b0, 2, 8, 8, 1'b1);
      mode = vin_pkg::MODE_VBI_HI;
      cfg;
      fld(1'b0, 2, 8, 8, 1'b1);
      pc = 3'h0;
      cfg;
      fld(1'b0, 241, 1284, 4, 1'b0);
      mode = vin_pkg::MODE_OFF;
      cfg;
      fld(1'b0, 1, 4, 4, 1'b0);
      check("reserve", 56'h0, 56'(sq_res));
      pol <= 4'h0;
      cfg;
      u_src.vs_edge(1'b0);
      mode = vin_pkg::MODE_VBI_LO;
      cfg;
      fld(1'b0, 2, 4, 4, 1'b1);
      // a line with no active bytes still moves the line address
      fld(1'b0, 2, 0, 4, 1'b0);
      // widest pitch doubled on a blanking line
      pc = 3'h7;
      cfg;
      fld(1'b0, 2, 4, 4, 1'b1);
      tally_and_finish;
   end
   // hang guard
   initial
   begin
      #5_000_000 failures++;
      tally_and_finish;
   end
endmodule
`default_nettype wire
